/* File: design/pcg_clock_gen.sv */
// Clock generator: crystal path, feedback divider, lock detect, base select.
//******************************************************************
//******************************************************************
`timescale 1ns/100ps
`default_nettype none
`include "pcg_defs.svh"
module pcg_clock_gen #(
	parameter int N_W = `PCG_N_W
) (
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_in,
	input  wire logic                 osc_in,
	input  wire logic                 vco_in,
	input  wire logic                 osc_enable_from_integration_in,
	input  wire logic                 osc_run_in_stop_in,
	input  wire logic                 pll_on_in,
	input  wire logic                 auto_bw_in,
	input  wire logic                 filter_tracking_select_in,
	input  wire logic                 base_clock_select_in,
	input  wire logic                 lock_change_irq_enable_in,
	input  wire pcg_pkg::pcg_mult_t   mult_n_in,
	input  wire logic [`PCG_L_W-1:0]  lin_l_in,
	input  wire logic [`PCG_E_W-1:0]  range_e_in,
	output logic                      osc_run_out,
	output logic                      crystal_clock_out,
	output logic                      pll_reference_clock_out,
	output logic                      vco_feedback_clock_out,
	output logic                      base_clock_out,
	output logic                      pump_up_out,
	output logic                      pump_down_out,
	output logic                      filter_tracking_select_out,
	output logic                      lock_out,
	output logic                      lock_irq_out,
	output logic [31:0]               centre_hz_out
);
	import pcg_pkg::*;

	if (N_W != `PCG_N_W) begin : g_n_w_check
		$error("N_W must match multiplier type width");
	end

	//**************************************************************
	// Input synchronisers
	//**************************************************************
	logic [1:0] osc_s1_r, osc_s2_r, osc_s3_r;
	logic [1:0] sync_nxt;
	always_comb begin
		sync_nxt = {vco_in, osc_in};
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			osc_s1_r <= 2'h0;
			osc_s2_r <= 2'h0;
			osc_s3_r <= 2'h0;
		end else begin
			osc_s1_r <= sync_nxt;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end
	logic xtal_s, vco_s, xtal_rise, vco_rise;
	logic osc_en;
	always_comb begin
		osc_en    = osc_enable_from_integration_in | osc_run_in_stop_in;
		xtal_s    = osc_s2_r[0] & osc_en;
		vco_s     = osc_s2_r[1] & pll_on_in;
		xtal_rise = xtal_s & ~osc_s3_r[0];
		vco_rise  = vco_s & ~osc_s3_r[1];
	end

	//**************************************************************
	// Dividers, detectors and mode
	//**************************************************************
	pcg_mult_t             fb_cnt_r, fb_cnt_nxt;
	logic                  fb_clk_r, fb_clk_nxt;
	logic                  xhalf_r, xhalf_nxt, vhalf_r, vhalf_nxt;
	logic                  up_r, up_nxt, dn_r, dn_nxt;
	logic [`PCG_CNT_W-1:0] diff_r, diff_nxt;
	logic                  lock_r, lock_nxt, irq_r, irq_nxt;
	logic                  base_r, base_nxt;
	pcg_mode_t             mode_r, mode_nxt;
	logic                  track_r, track_nxt;
	logic                  fb_rise;
	always_comb begin
		fb_cnt_nxt = fb_cnt_r;
		fb_clk_nxt = fb_clk_r;
		xhalf_nxt  = xhalf_r ^ xtal_rise;
		vhalf_nxt  = vhalf_r ^ vco_rise;
		fb_rise    = 1'b0;
		if (vco_rise) begin
			if (fb_cnt_r >= mult_n_in - 12'h001) begin
				fb_cnt_nxt = 12'h000;
				fb_clk_nxt = 1'b1;
				fb_rise    = ~fb_clk_r;
			end else begin
				fb_cnt_nxt = fb_cnt_r + 12'h001;
				if (fb_cnt_r >= (mult_n_in >> 1)) begin
					fb_clk_nxt = 1'b0;
				end
			end
		end
		up_nxt = xtal_rise & ~fb_rise;
		dn_nxt = fb_rise & ~xtal_rise;
		diff_nxt = diff_r;
		// A stale count from an idle loop would block lock at start.
		if (!pll_on_in) begin
			diff_nxt = `PCG_DIFF_MID;
		end else if (xtal_rise & ~fb_rise) begin
			diff_nxt = (diff_r == `PCG_DIFF_MAX) ? diff_r : diff_r + 4'h1;
		end else if (fb_rise & ~xtal_rise) begin
			diff_nxt = (diff_r == 4'h0) ? diff_r : diff_r - 4'h1;
		end
		mode_nxt = mode_r;
		lock_nxt = 1'b0;
		if (!pll_on_in) begin
			mode_nxt = PCG_ACQUIRE;
		end else if (auto_bw_in) begin
			if (diff_r >= `PCG_DIFF_MID - `PCG_TRACK_WIN
			    && diff_r <= `PCG_DIFF_MID + `PCG_TRACK_WIN) begin
				mode_nxt = PCG_TRACK;
			end else begin
				mode_nxt = PCG_ACQUIRE;
			end
			lock_nxt = (diff_r >= `PCG_DIFF_MID - `PCG_LOCK_WIN)
			    && (diff_r <= `PCG_DIFF_MID + `PCG_LOCK_WIN);
		end else begin
			mode_nxt = filter_tracking_select_in ? PCG_TRACK : PCG_ACQUIRE;
		end
		irq_nxt = auto_bw_in & lock_change_irq_enable_in & (lock_nxt ^ lock_r);
		// halved source for the base clock.
		base_nxt  = base_clock_select_in ? vhalf_r : xhalf_r;
		track_nxt = (mode_nxt == PCG_TRACK);
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			fb_cnt_r <= 12'h000;
			fb_clk_r <= 1'b0;
			xhalf_r  <= 1'b0;
			vhalf_r  <= 1'b0;
			up_r     <= 1'b0;
			dn_r     <= 1'b0;
			diff_r   <= `PCG_DIFF_MID;
			lock_r   <= 1'b0;
			irq_r    <= 1'b0;
			base_r   <= 1'b0;
			mode_r   <= PCG_ACQUIRE;
			track_r  <= 1'b0;
		end else begin
			fb_cnt_r <= fb_cnt_nxt;
			fb_clk_r <= fb_clk_nxt;
			xhalf_r  <= xhalf_nxt;
			vhalf_r  <= vhalf_nxt;
			up_r     <= up_nxt;
			dn_r     <= dn_nxt;
			diff_r   <= diff_nxt;
			lock_r   <= lock_nxt;
			irq_r    <= irq_nxt;
			base_r   <= base_nxt;
			mode_r   <= mode_nxt;
			track_r  <= track_nxt;
		end
	end

	//**************************************************************
	// Registered outputs
	//**************************************************************
	logic xo_r, ro_r, osc_run_r;
	logic [31:0] centre_r, centre_nxt;
	always_comb begin
		centre_nxt = 32'(({24'h0, lin_l_in} << range_e_in) * `PCG_FNOM_HZ);
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			xo_r      <= 1'b0;
			ro_r      <= 1'b0;
			osc_run_r <= 1'b0;
			centre_r  <= 32'h0;
		end else begin
			xo_r      <= xtal_s;
			ro_r      <= xtal_s;
			osc_run_r <= osc_en;
			centre_r  <= centre_nxt;
		end
	end
	assign osc_run_out             = osc_run_r;
	assign crystal_clock_out       = xo_r;
	assign pll_reference_clock_out = ro_r;
	assign vco_feedback_clock_out  = fb_clk_r;
	assign base_clock_out          = base_r;
	assign pump_up_out             = up_r;
	assign pump_down_out           = dn_r;
	assign filter_tracking_select_out = track_r;
	assign lock_out                = lock_r;
	assign lock_irq_out            = irq_r;
	assign centre_hz_out           = centre_r;
endmodule : pcg_clock_gen
`default_nettype wire

/* File: pkg/pcg_defs.svh */
// Constants for the clock generator block.
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH
`define PCG_N_W          12
`define PCG_N_RESET      12'h040
`define PCG_L_W          8
`define PCG_E_W          2
`define PCG_FNOM_HZ      32'h000116E8
`define PCG_LOCK_WIN     4'h2
`define PCG_TRACK_WIN    4'h4
`define PCG_CNT_W        4
`define PCG_DIFF_MID     4'h8
`define PCG_DIFF_MAX     4'hF
`define PCG_REF_DIV      8'h01
`endif

/* File: pkg/pcg_pkg.sv */
// Types for the clock generator block.
`default_nettype none
package pcg_pkg;
	typedef enum logic [1:0] {
		PCG_ACQUIRE = 2'b01,
		PCG_TRACK   = 2'b10
	} pcg_mode_t;
	typedef logic [11:0] pcg_mult_t;
endpackage : pcg_pkg
`default_nettype wire

/* File: tb/pcg_siu_model.sv */
// Integration unit model: bus clock and system clock source.
`timescale 1ns/100ps
`default_nettype none
module pcg_siu_model (
	input  wire logic core_clk_in, rst_in, base_in, xtal_in, use_xtal_in,
	output var  logic bus_out,
	output wire logic sys_out
);
	logic q_r;
	// Bus toggles on each base rise, so never above half base.
	always_ff @(posedge core_clk_in or posedge rst_in)
		{q_r, bus_out} <= rst_in ? 2'h0 : {base_in, bus_out ^ (base_in & ~q_r)};
	assign sys_out = use_xtal_in ? xtal_in : base_in;
endmodule : pcg_siu_model
`default_nettype wire

/* File: tb/pcg_clock_gen_sva.sv */
// Port checker for the clock generator.
`timescale 1ns/100ps
`default_nettype none
module pcg_clock_gen_sva (
	input wire logic core_clk_in, rst_in, pll_on_in, auto_bw_in, lock_out,
	input wire logic osc_enable_from_integration_in, osc_run_in_stop_in,
	input wire logic filter_tracking_select_in, lock_change_irq_enable_in,
	input wire logic osc_run_out, filter_tracking_select_out, lock_irq_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	wire logic en_w = osc_enable_from_integration_in || osc_run_in_stop_in;
	wire logic trk_w = pll_on_in && !auto_bw_in && filter_tracking_select_in;
	wire logic acq_w = pll_on_in && !auto_bw_in && !filter_tracking_select_in;
	chk_osc_on: assert property (en_w[*4] |-> osc_run_out)
		else $error("osc stopped");
	chk_osc_off: assert property ((!en_w)[*4] |-> !osc_run_out)
		else $error("osc running");
	chk_manual_quiet: assert property ((!auto_bw_in)[*4] |->
		!lock_out && !lock_irq_out) else $error("manual lock");
	chk_irq_cause: assert property (lock_irq_out |->
		$changed(lock_out) && $past(auto_bw_in)) else $error("stray irq");
	chk_irq_toggle: assert property ($changed(lock_out) &&
		$past(auto_bw_in && lock_change_irq_enable_in) |-> lock_irq_out)
		else $error("irq lost");
	chk_irq_masked: assert property ((!lock_change_irq_enable_in)[*3]
		|-> !lock_irq_out) else $error("irq masked");
	chk_track_set: assert property (trk_w[*4]
		|-> filter_tracking_select_out) else $error("not tracking");
	chk_acq_clear: assert property (acq_w[*4]
		|-> !filter_tracking_select_out) else $error("tracking in acq");
	cover property (lock_irq_out);
	cover property (lock_out && filter_tracking_select_out);
	cover property (trk_w && filter_tracking_select_out);
endmodule : pcg_clock_gen_sva
bind pcg_clock_gen pcg_clock_gen_sva i_pcg_clock_gen_sva (.*);
`default_nettype wire

/* File: tb/tb_pcg_clock_gen.sv */
// Testbench of the clock generator with an integration unit model.
`timescale 1ns/100ps
`default_nettype none
module tb_pcg_clock_gen;
	import pcg_pkg::*;
	logic core_clk_in = 1'b0;
	logic rst_in, osc_in, vco_in, pll_on_in, auto_bw_in, use_xtal, bus_clk;
	logic osc_enable_from_integration_in, osc_run_in_stop_in, sys_clk;
	logic filter_tracking_select_in, base_clock_select_in, lock_out;
	logic lock_change_irq_enable_in, osc_run_out, crystal_clock_out;
	logic pll_reference_clock_out, vco_feedback_clock_out, base_clock_out;
	logic pump_up_out, pump_down_out, filter_tracking_select_out, lock_irq_out;
	pcg_mult_t mult_n_in;
	logic [7:0] lin_l_in;
	logic [1:0] range_e_in;
	logic [31:0] centre_hz_out;
	logic [10:0] mon, mon_q;
	int c [11];
	int fail_count, n_compared, cyc, od = 8, vd = 2, oc, vc;
	pcg_clock_gen i_pcg_clock_gen (.*);
	pcg_siu_model i_pcg_siu_model (.core_clk_in, .rst_in,
		.base_in(base_clock_out), .xtal_in(crystal_clock_out),
		.use_xtal_in(use_xtal), .bus_out(bus_clk), .sys_out(sys_clk));
	assign mon = {pump_down_out, pump_up_out, vco_in, osc_in, sys_clk,
		bus_clk, lock_irq_out,
		vco_feedback_clock_out, base_clock_out, pll_reference_clock_out,
		crystal_clock_out};
	initial forever #2 core_clk_in = !core_clk_in;
	// Edge counters, pin stimulus and the hang limit.
	always @(posedge core_clk_in) begin
		mon_q <= mon;
		foreach (c[i]) if (mon[i] && !mon_q[i]) c[i] <= c[i] + 1;
		oc <= (oc >= od - 1) ? 0 : oc + 1;
		vc <= (vc >= vd - 1) ? 0 : vc + 1;
		osc_in <= osc_in ^ (oc >= od - 1);
		vco_in <= vco_in ^ (vc >= vd - 1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	task check(input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t: %0h not %0h", $time, seen, exp);
		end
	endtask : check
	// Edge counts may differ by the phase of the window.
	task near(input int a, b, t);
		check(32'(a - b <= t && b - a <= t), 32'h1);
	endtask : near
	task win(input int n);
		@(negedge core_clk_in);
		c = '{default: 0};
		repeat (n) @(negedge core_clk_in);
	endtask : win
	task t_osc;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk_in);
			{osc_enable_from_integration_in, osc_run_in_stop_in} <= 2'(i);
			win(200);
			check(32'(osc_run_out), 32'(i != 0)); // enable
			near(c[0], i ? c[7] : 0, 1); // rate
			near(c[1], c[0], 1); // copy
			near(c[9], c[0], 1); // lead pulses
			check(c[10], 32'h0); // no lag pulses
		end
		near(2 * c[2], c[7], 2); // crystal half
		near(2 * c[5], c[2], 2); // bus half
		near(c[6], c[0], 1); // crystal source
	endtask : t_osc
	task t_pll;
		@(posedge core_clk_in);
		{pll_on_in, auto_bw_in, lock_change_irq_enable_in, use_xtal} <= 4'hE;
		win(8);
		check(centre_hz_out, 32'h01E81600); // centre
		wait (lock_out === 1'b1);
		check({lock_out, filter_tracking_select_out}, 32'h3);
		check(c[4], 32'h1); // entry
		@(posedge core_clk_in);
		// VCO selected as base source once locked.
		base_clock_select_in <= 1'b1;
		win(400);
		near(4 * c[3], c[8], 4); // divide
		near(2 * c[2], c[8], 2); // vco half
		near(c[6], c[2], 1); // base source
		near(c[9], c[0], 1); // reference pulses
		near(c[10], c[3], 1); // feedback pulses
		c = '{default: 0};
		// A stalled VCO drifts one way only, so lock drops just once.
		vd = 1000;
		wait (filter_tracking_select_out === 1'b0);
		repeat (8) @(negedge core_clk_in);
		check({lock_out, filter_tracking_select_out}, 32'h0);
		check(c[4], 32'h1); // exit
	endtask : t_pll
	task t_manual;
		@(posedge core_clk_in);
		{pll_on_in, auto_bw_in, filter_tracking_select_in} <= 3'h0;
		@(posedge core_clk_in);
		// tracking bit clear while the PLL starts.
		pll_on_in <= 1'b1;
		win(8);
		check({lock_out, filter_tracking_select_out}, 32'h0);
		check(c[4], 32'h0); // no irq
		@(posedge core_clk_in);
		filter_tracking_select_in <= 1'b1;
		win(8);
		check({lock_out, filter_tracking_select_out}, 32'h1);
		check(c[4], 32'h0); // no irq
	endtask : t_manual
	initial begin
		{rst_in, use_xtal, osc_in, vco_in, pll_on_in, auto_bw_in} = 6'h30;
		{osc_enable_from_integration_in, osc_run_in_stop_in} = 2'h0;
		{filter_tracking_select_in, lock_change_irq_enable_in} = 2'h0;
		base_clock_select_in = 1'b0;
		{mult_n_in, lin_l_in, range_e_in} = {12'h004, 8'h70, 2'h2};
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		t_osc();
		t_pll();
		t_manual();
		print_verdict();
	end
	task print_verdict;
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
endmodule : tb_pcg_clock_gen
`default_nettype wire
